// >>> rtl/bhm_multiplier.sv
// Byte hardware multiplier with product register pair
`timescale 1ns/1ps
`default_nettype none
module bhm_multiplier #(
  parameter int unsigned OPW = bhm_pkg::BHM_OPW
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic multiply_working_by_file,
  input wire logic [OPW-1:0] working_register,
  input wire logic [OPW-1:0] file_operand,
  input wire logic [OPW-1:0] status_in,
  input wire logic wr_product_high,
  input wire logic wr_product_low,
  input wire logic [OPW-1:0] wr_data,
  output logic [OPW-1:0] product_high_byte,
  output logic [OPW-1:0] product_low_byte,
  output logic [OPW-1:0] status_out
);
  logic [OPW-1:0] prod_hi_ff;
  logic [OPW-1:0] prod_lo_ff;
  logic [OPW-1:0] status_ff;
  localparam int unsigned PRW = 2 * OPW;
  wire [PRW-1:0] full_product;
  wire [OPW-1:0] nxt_prod_hi;
  wire [OPW-1:0] nxt_prod_lo;
  wire [PRW-1:0] pp_sum [0:OPW];
  wire [PRW-1:0] w_ext;

  // Working register operand, zero extended so shifts keep every bit
  assign w_ext = {{OPW{1'b0}}, working_register};
  assign pp_sum[0] = '0;
  // Shift-add rows, one per file operand bit; settles within the cycle
  for (genvar gi = 0; gi < OPW; gi++) begin : g_row
    wire [PRW-1:0] row_term;
    assign row_term = file_operand[gi] ? (w_ext << gi) : '0;
    assign pp_sum[gi+1] = pp_sum[gi] + row_term;
  end
  // Last row is the full unsigned product
  assign full_product = pp_sum[OPW];
  // Multiply wins over a same-cycle software write
  assign nxt_prod_hi = multiply_working_by_file ? full_product[2*OPW-1:OPW] :
                       wr_product_high ? wr_data : prod_hi_ff;
  assign nxt_prod_lo = multiply_working_by_file ? full_product[OPW-1:0] :
                       wr_product_low ? wr_data : prod_lo_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prod_hi_ff <= bhm_pkg::BHM_PROD_RST;
      prod_lo_ff <= bhm_pkg::BHM_PROD_RST;
      status_ff <= bhm_pkg::BHM_PROD_RST;
    end else begin
      prod_hi_ff <= nxt_prod_hi;
      prod_lo_ff <= nxt_prod_lo;
      // Flags pass through unchanged, multiply has no flag path
      status_ff <= status_in;
    end
  end

  assign product_high_byte = prod_hi_ff;
  assign product_low_byte = prod_lo_ff;
  assign status_out = status_ff;

  mul_result_a: assert property (@(posedge mclk) disable iff (!rst_n)
    multiply_working_by_file |=> {product_high_byte, product_low_byte} ==
      $past(working_register) * $past(file_operand))
    else $error("product mismatch");
  hold_hi_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !multiply_working_by_file && !wr_product_high |=> $stable(product_high_byte))
    else $error("high byte changed without cause");
  hold_lo_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !multiply_working_by_file && !wr_product_low |=> $stable(product_low_byte))
    else $error("low byte changed without cause");
  sw_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !multiply_working_by_file && wr_product_high |=> product_high_byte == $past(wr_data))
    else $error("software write lost");
  flags_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    multiply_working_by_file |=> status_out == $past(status_in))
    else $error("flags altered by multiply");

  // Request shapes seen by the core side in one cycle
  sequence mul_req_s;
    multiply_working_by_file;
  endsequence

  sequence idle_s;
    !multiply_working_by_file;
  endsequence

  sequence quiet_s;
    !multiply_working_by_file && !wr_product_high && !wr_product_low;
  endsequence

  sequence wr_hi_req_s;
    !multiply_working_by_file && wr_product_high;
  endsequence

  sequence wr_lo_req_s;
    !multiply_working_by_file && wr_product_low;
  endsequence

  sequence wr_both_s;
    !multiply_working_by_file && wr_product_high && wr_product_low;
  endsequence

  sequence hi_only_s;
    !multiply_working_by_file && wr_product_high && !wr_product_low;
  endsequence

  sequence lo_only_s;
    !multiply_working_by_file && !wr_product_high && wr_product_low;
  endsequence

  sequence clash_req_s;
    multiply_working_by_file && (wr_product_high || wr_product_low);
  endsequence

  sequence zero_op_s;
    multiply_working_by_file && (working_register == '0 || file_operand == '0);
  endsequence

  sequence unit_op_s;
    multiply_working_by_file && file_operand == OPW'(1);
  endsequence

  sequence max_op_s;
    multiply_working_by_file && working_register == '1 && file_operand == '1;
  endsequence

  // Software access to the product pair
  property p_sw_write_lo;
    @(posedge mclk) disable iff (!rst_n)
      wr_lo_req_s |=> product_low_byte == $past(wr_data);
  endproperty
  sw_write_lo_a: assert property (p_sw_write_lo)
    else $error("low byte software write lost");

  property p_both_write;
    @(posedge mclk) disable iff (!rst_n)
      wr_both_s |=> product_high_byte == $past(wr_data) && product_low_byte == $past(wr_data);
  endproperty
  both_write_a: assert property (p_both_write)
    else $error("paired software write lost");

  property p_hi_only;
    @(posedge mclk) disable iff (!rst_n)
      hi_only_s |=> $stable(product_low_byte);
  endproperty
  hi_only_a: assert property (p_hi_only)
    else $error("high byte write touched low byte");

  property p_lo_only;
    @(posedge mclk) disable iff (!rst_n)
      lo_only_s |=> $stable(product_high_byte);
  endproperty
  lo_only_a: assert property (p_lo_only)
    else $error("low byte write touched high byte");

  // Multiply priority and throughput
  property p_clash;
    @(posedge mclk) disable iff (!rst_n)
      clash_req_s |=> {product_high_byte, product_low_byte} ==
        $past(working_register) * $past(file_operand);
  endproperty
  clash_prio_a: assert property (p_clash)
    else $error("software write beat a multiply");

  property p_back_to_back;
    @(posedge mclk) disable iff (!rst_n)
      mul_req_s ##1 mul_req_s |=> {product_high_byte, product_low_byte} ==
        $past(working_register) * $past(file_operand);
  endproperty
  back_to_back_a: assert property (p_back_to_back)
    else $error("back to back multiply lost");

  property p_mul_over_write;
    @(posedge mclk) disable iff (!rst_n)
      wr_hi_req_s ##1 mul_req_s |=> {product_high_byte, product_low_byte} ==
        $past(working_register) * $past(file_operand);
  endproperty
  mul_over_write_a: assert property (p_mul_over_write)
    else $error("multiply after write lost");

  property p_prod_kept;
    @(posedge mclk) disable iff (!rst_n)
      mul_req_s ##1 quiet_s |=> $stable(product_high_byte) && $stable(product_low_byte);
  endproperty
  prod_kept_a: assert property (p_prod_kept)
    else $error("product not held");

  // Arithmetic corners
  property p_zero_op;
    @(posedge mclk) disable iff (!rst_n)
      zero_op_s |=> product_high_byte == '0 && product_low_byte == '0;
  endproperty
  zero_op_a: assert property (p_zero_op)
    else $error("zero operand gave nonzero product");

  property p_unit_op;
    @(posedge mclk) disable iff (!rst_n)
      unit_op_s |=> product_high_byte == '0 && product_low_byte == $past(working_register);
  endproperty
  unit_op_a: assert property (p_unit_op)
    else $error("multiply by one wrong");

  property p_max_op;
    @(posedge mclk) disable iff (!rst_n)
      max_op_s |=> product_high_byte == {{(OPW-1){1'b1}}, 1'b0} &&
        product_low_byte == {{(OPW-1){1'b0}}, 1'b1};
  endproperty
  max_op_a: assert property (p_max_op)
    else $error("largest operands gave wrong product");

  property p_hi_bound;
    @(posedge mclk) disable iff (!rst_n)
      mul_req_s |=> product_high_byte <= $past(working_register) &&
        product_high_byte <= $past(file_operand);
  endproperty
  hi_bound_a: assert property (p_hi_bound)
    else $error("high byte above an operand");

  property p_lsb_check;
    @(posedge mclk) disable iff (!rst_n)
      mul_req_s |=> product_low_byte[0] == ($past(working_register[0]) && $past(file_operand[0]));
  endproperty
  lsb_check_a: assert property (p_lsb_check)
    else $error("product lowest bit wrong");

  // Flags never take part in a multiply
  property p_flags_idle;
    @(posedge mclk) disable iff (!rst_n)
      idle_s |=> status_out == $past(status_in);
  endproperty
  flags_idle_a: assert property (p_flags_idle)
    else $error("flags altered without multiply");

  property p_flags_clash;
    @(posedge mclk) disable iff (!rst_n)
      clash_req_s |=> status_out == $past(status_in);
  endproperty
  flags_clash_a: assert property (p_flags_clash)
    else $error("flags altered by multiply with write");

  // Reset clears the pair; watched while reset is applied
  property p_reset_val;
    @(posedge mclk)
      !rst_n |=> product_high_byte == bhm_pkg::BHM_PROD_RST &&
        product_low_byte == bhm_pkg::BHM_PROD_RST && status_out == bhm_pkg::BHM_PROD_RST;
  endproperty
  reset_val_a: assert property (p_reset_val)
    else $error("reset value wrong");
endmodule
`default_nettype wire

// >>> rtl/bhm_pkg.sv
// Constants for the byte hardware multiplier
`default_nettype none
package bhm_pkg;
  localparam int unsigned BHM_OPW = 8;
  localparam int unsigned BHM_PRW = 16;
  localparam logic [7:0] BHM_PROD_RST = 8'h00;
  localparam int unsigned BHM_MUL_CYCLES = 1;
endpackage
`default_nettype wire

// >>> test/bhm_core_model.sv
// Core side model issuing multiply requests
`timescale 1ns/1ps
`default_nettype none
module bhm_core_model (
  input wire logic mclk,
  input wire logic [16:0] req,
  output logic mul,
  output logic [15:0] ops
);
  always @(posedge mclk) {mul, ops} <= req;
endmodule
`default_nettype wire

// >>> test/byte_hardware_multiplier_tb_top.sv
// Random bench for the byte multiplier
`timescale 1ns/1ps
`default_nettype none
module byte_hardware_multiplier_tb_top;
  logic mclk = 0, rst_n = 0, wh = 0, wl = 0, mul;
  logic [16:0] req = '0;
  logic [15:0] ops, exp_p = '0;
  logic [7:0] wd = '0, st = '0, ph, pl, so, exp_s = '0;
  int failures = 0, total_checks = 0;
  logic [7:0] rh = '0, rl = '0;
  always #4 mclk = ~mclk;
  bhm_core_model i_core (.mclk(mclk), .req(req), .mul(mul), .ops(ops));
  bhm_multiplier i_dut (.mclk(mclk), .rst_n(rst_n), .multiply_working_by_file(mul),
    .working_register(ops[15:8]), .file_operand(ops[7:0]), .status_in(st),
    .wr_product_high(wh), .wr_product_low(wl), .wr_data(wd), .product_high_byte(ph),
    .product_low_byte(pl), .status_out(so));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [15:0] prod(input logic [15:0] o);
    return {8'h00, o[15:8]} * {8'h00, o[7:0]};
  endfunction
  // One multiply through the core model; product read at the falling edge after capture
  task automatic mul_once(input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    req <= {1'b1, a, b};
    @(posedge mclk);
    req <= 17'h00000;
    @(posedge mclk);
    @(negedge mclk);
    rh = ph;
    rl = pl;
  endtask
  task automatic signed_8x8(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    logic [15:0] e;
    mul_once(a, b);
    p = {rh, rl};
    if (b[7]) p[15:8] = p[15:8] - a;
    if (a[7]) p[15:8] = p[15:8] - b;
    e = {{8{a[7]}}, a} * {{8{b[7]}}, b};
    chk("signed 8x8", p, e);
  endtask
  task automatic wide_16x16(input logic [15:0] x, input logic [15:0] y, input logic sgn);
    logic [31:0] res;
    logic [31:0] expv;
    mul_once(x[7:0], y[7:0]);
    res = {16'h0000, rh, rl};
    mul_once(x[15:8], y[15:8]);
    res = res + {rh, rl, 16'h0000};
    mul_once(x[7:0], y[15:8]);
    res = res + {8'h00, rh, rl, 8'h00};
    mul_once(x[15:8], y[7:0]);
    res = res + {8'h00, rh, rl, 8'h00};
    if (sgn && y[15]) res = res - {x, 16'h0000};
    if (sgn && x[15]) res = res - {y, 16'h0000};
    expv = sgn ? ({{16{x[15]}}, x} * {{16{y[15]}}, y}) : ({16'h0000, x} * {16'h0000, y});
    chk("wide low", res[15:0], expv[15:0]);
    chk("wide high", res[31:16], expv[31:16]);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Multiply wins over a write in the same cycle
  always @(posedge mclk) begin
    exp_s <= rst_n ? st : 8'h00;
    if (!rst_n) exp_p <= 16'h0000;
    else if (mul) exp_p <= prod(ops);
    else exp_p <= {wh ? wd : exp_p[15:8], wl ? wd : exp_p[7:0]};
  end
  always @(negedge mclk) begin
    chk("product", {ph, pl}, exp_p);
    chk("status", {8'h00, so}, {8'h00, exp_s});
  end
  initial begin
    void'($urandom(8434));
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk);
      req <= i < 2 ? (i ? 17'h1FFFF : 17'h1FF00) : 17'($urandom);
      {wh, wl, wd, st} <= 18'($urandom);
    end
    repeat (3) @(posedge mclk);
    wh <= 1'b0;
    wl <= 1'b0;
    signed_8x8(8'h80, 8'h80);
    signed_8x8(8'hFF, 8'h01);
    signed_8x8(8'h7F, 8'h81);
    wide_16x16(16'hFFFF, 16'hFFFF, 1'b0);
    wide_16x16(16'hFFFF, 16'hFFFF, 1'b1);
    wide_16x16(16'h8000, 16'h7FFF, 1'b1);
    for (int i = 0; i < 40; i++) begin
      signed_8x8(8'($urandom), 8'($urandom));
      wide_16x16(16'($urandom), 16'($urandom), 1'($urandom));
    end
    repeat (3) @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
